// ### rtl/contact_speed_mode_select.sv
// Top of the contact speed and mode selector with its Avalon-MM register slave.
// Assumes contact pins are active low and the position loop reports completion.
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module contact_speed_mode_select
	import csms_pkg::*;
#(
	parameter int SETTLE = SETTLE_CYCLES
) (
	// Clock and reset
	input  wire logic               clock_i,
	input  wire logic               rst_i,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0]  avs_address_i,
	input  wire logic               avs_read_i,
	input  wire logic               avs_write_i,
	input  wire logic [31:0]        avs_writedata_i,
	input  wire logic [3:0]         avs_byteenable_i,
	output logic [31:0]             avs_readdata_o,
	output logic                    avs_waitrequest_o,
	// Contact pins, active low
	input  wire logic               multi_function_input_n_i,
	input  wire logic               speed_select_a_n_i,
	input  wire logic               speed_select_b_n_i,
	// Servo loop side
	input  wire logic               positioning_complete_i,
	input  wire logic               motor_running_i,
	input  wire logic               reference_pulse_i,
	output logic                    reference_pulse_o,
	output logic                    pulses_blocked_o,
	// Decoded operation
	output logic                    direction_reverse_o,
	output logic [1:0]              loop_mode_o,
	output logic [2:0]              speed_source_o,
	output logic [SPEED_W-1:0]      preset_speed_o,
	output logic                    soft_start_enable_o,
	output logic                    proportional_only_o,
	output logic                    zero_clamp_o,
	output logic                    inhibit_o,
	output logic                    forward_limit_input_o,
	output logic                    reverse_limit_input_o
);

	sel_if u_sel ();

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [3:0]         control_method_setting_q;
	logic [1:0]         analog_input_usage_q;
	logic [SPEED_W-1:0] preset_speed_one_q;
	logic [SPEED_W-1:0] preset_speed_two_q;
	logic [SPEED_W-1:0] preset_speed_three_q;
	logic               ack_q;
	logic [31:0]        rdata_q;
	logic               wr_go;
	logic [31:0]        ctl_new, spd_new;

	// ------------------------------------------------------------
	// Decoded state
	// ------------------------------------------------------------
	logic               dir_q, dir_d;
	loop_e              loop_q, loop_d;
	src_e               src_q, src_d;
	logic [SPEED_W-1:0] speed_q, speed_d;
	logic               soft_q, soft_d;
	logic               pmode_q, pmode_d;
	logic               zclamp_q, zclamp_d;
	logic               inhibit_q, inhibit_d;
	logic               flim_q, flim_d;
	logic               rlim_q, rlim_d;
	logic [31:0]        status;

	logic mfi;
	logic sel_a;
	logic sel_b;

	function automatic logic [31:0] merge(input logic [31:0] old_v,
	                                      input logic [31:0] new_v,
	                                      input logic [3:0]  be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	contact_sync #(
		.STAGES (SYNC_STAGES),
		.SETTLE (SETTLE)
	) u_sync (
		.clock_i                  (clock_i),
		.rst_i                    (rst_i),
		.multi_function_input_n_i (multi_function_input_n_i),
		.speed_select_a_n_i       (speed_select_a_n_i),
		.speed_select_b_n_i       (speed_select_b_n_i),
		.sel                      (u_sel.sync_mp)
	);

	pulse_gate u_gate (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.sel     (u_sel.gate_mp)
	);

	assign mfi   = u_sel.multi_function_on;
	assign sel_a = u_sel.speed_a_on;
	assign sel_b = u_sel.speed_b_on;

	// A running hop from a preset straight into pulse following arms the gate
	assign u_sel.enter_pulse   = is_preset(src_q) && (src_d == SRC_PULSE);
	assign u_sel.motor_running = motor_running_i;
	assign u_sel.positioning_complete          = positioning_complete_i;
	assign u_sel.pulse_in      = reference_pulse_i;
	assign u_sel.pulse_mode    = (src_q == SRC_PULSE);

	// ------------------------------------------------------------
	// Avalon-MM slave
	// ------------------------------------------------------------
	// One wait cycle per access; read data are latched in that wait cycle
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
	assign avs_readdata_o    = rdata_q;
	assign wr_go             = avs_write_i & ack_q;
	assign ctl_new = merge({26'h0, analog_input_usage_q, control_method_setting_q},
	                       avs_writedata_i, avs_byteenable_i);
	assign spd_new = merge(32'(avs_address_i == OFS_SPEED1 ? preset_speed_one_q :
	                           avs_address_i == OFS_SPEED2 ? preset_speed_two_q :
	                           preset_speed_three_q), avs_writedata_i, avs_byteenable_i);

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read_i && !ack_q) begin
			case (avs_address_i)
				OFS_CONTROL: begin
					rdata_q <= {26'h0, analog_input_usage_q, control_method_setting_q};
				end
				OFS_STATUS: rdata_q <= status;
				OFS_SPEED1: rdata_q <= {18'h0, preset_speed_one_q};
				OFS_SPEED2: rdata_q <= {18'h0, preset_speed_two_q};
				OFS_SPEED3: rdata_q <= {18'h0, preset_speed_three_q};
				default:    rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			control_method_setting_q <= METHOD_RST;
			analog_input_usage_q     <= USAGE_RST;
		end else if (wr_go && avs_address_i == OFS_CONTROL) begin
			control_method_setting_q <= ctl_new[CTL_METHOD_LSB +: 4];
			analog_input_usage_q     <= ctl_new[CTL_USAGE_LSB +: 2];
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			preset_speed_one_q   <= SPEED1_RST;
			preset_speed_two_q   <= SPEED2_RST;
			preset_speed_three_q <= SPEED3_RST;
		end else if (wr_go) begin
			case (avs_address_i)
				OFS_SPEED1: preset_speed_one_q   <= spd_new[SPEED_W-1:0];
				OFS_SPEED2: preset_speed_two_q   <= spd_new[SPEED_W-1:0];
				OFS_SPEED3: preset_speed_three_q <= spd_new[SPEED_W-1:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		status = 32'h0000_0000;
		status[ST_DIR]               = dir_q;
		status[ST_SRC_LSB +: 3]      = src_q;
		status[ST_LOOP_LSB +: 2]     = loop_q;
		status[ST_BLOCKED]           = u_sel.blocked;
		status[ST_PMODE]             = pmode_q;
		status[ST_ZCLAMP]            = zclamp_q;
		status[ST_INHIBIT]           = inhibit_q;
		status[ST_FLIM]              = flim_q;
		status[ST_RLIM]              = rlim_q;
		status[ST_SOFT]              = soft_q;
		status[ST_USAGE_LSB +: 2]    = analog_input_usage_q;
	end

	// ------------------------------------------------------------
	// Operation decode
	// ------------------------------------------------------------
	always_comb begin
		dir_d     = 1'b0;
		loop_d    = LOOP_SPEED;
		src_d     = SRC_ANALOG_SPEED;
		soft_d    = 1'b0;
		pmode_d   = 1'b0;
		zclamp_d  = 1'b0;
		inhibit_d = 1'b0;
		flim_d    = 1'b0;
		rlim_d    = 1'b0;
		if (is_contact_speed(control_method_setting_q)) begin
			dir_d = mfi;
			case ({sel_a, sel_b})
				2'b01:   src_d = SRC_PRESET1;
				2'b11:   src_d = SRC_PRESET2;
				2'b10:   src_d = SRC_PRESET3;
				default: begin
					case (control_method_setting_q)
						CM_CS_STOP:   src_d = SRC_ZERO;
						CM_CS_ANALOG: src_d = SRC_ANALOG_SPEED;
						CM_CS_PULSE:  src_d = SRC_PULSE;
						default:      src_d = SRC_ANALOG_TORQUE;
					endcase
				end
			endcase
			case (src_d)
				SRC_PULSE:         loop_d = LOOP_POSITION;
				SRC_ANALOG_TORQUE: loop_d = LOOP_TORQUE;
				default:           loop_d = LOOP_SPEED;
			endcase
			// Soft start never shapes pulse following or torque
			soft_d = (loop_d == LOOP_SPEED);
		end else begin
			flim_d = sel_a;
			rlim_d = sel_b;
			case (control_method_setting_q)
				CM_SPEED: begin
					pmode_d = mfi;
				end
				CM_POSITION: begin
					loop_d  = LOOP_POSITION;
					pmode_d = mfi;
				end
				CM_TORQUE:      loop_d = LOOP_TORQUE;
				CM_POS_SPD:     loop_d = mfi ? LOOP_SPEED : LOOP_POSITION;
				CM_POS_TRQ:     loop_d = mfi ? LOOP_TORQUE : LOOP_POSITION;
				CM_TRQ_SPD:     loop_d = mfi ? LOOP_SPEED : LOOP_TORQUE;
				CM_SPD_ZCLAMP:  zclamp_d = mfi;
				CM_POS_INHIBIT: begin
					loop_d    = LOOP_POSITION;
					inhibit_d = mfi;
				end
				default: ;
			endcase
			case (loop_d)
				LOOP_POSITION: src_d = SRC_PULSE;
				LOOP_TORQUE:   src_d = SRC_ANALOG_TORQUE;
				default:       src_d = zclamp_d ? SRC_ZERO : SRC_ANALOG_SPEED;
			endcase
		end
		case (src_d)
			SRC_PRESET1: speed_d = preset_speed_one_q;
			SRC_PRESET2: speed_d = preset_speed_two_q;
			SRC_PRESET3: speed_d = preset_speed_three_q;
			default:     speed_d = '0;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			dir_q     <= 1'b0;
			loop_q    <= LOOP_SPEED;
			src_q     <= SRC_ANALOG_SPEED;
			speed_q   <= '0;
			soft_q    <= 1'b0;
			pmode_q   <= 1'b0;
			zclamp_q  <= 1'b0;
			inhibit_q <= 1'b0;
			flim_q    <= 1'b0;
			rlim_q    <= 1'b0;
		end else begin
			dir_q     <= dir_d;
			loop_q    <= loop_d;
			src_q     <= src_d;
			speed_q   <= speed_d;
			soft_q    <= soft_d;
			pmode_q   <= pmode_d;
			zclamp_q  <= zclamp_d;
			inhibit_q <= inhibit_d;
			flim_q    <= flim_d;
			rlim_q    <= rlim_d;
		end
	end

	assign direction_reverse_o   = dir_q;
	assign loop_mode_o           = loop_q;
	assign speed_source_o        = src_q;
	assign preset_speed_o        = speed_q;
	assign soft_start_enable_o   = soft_q;
	assign proportional_only_o   = pmode_q;
	assign zero_clamp_o          = zclamp_q;
	assign inhibit_o             = inhibit_q;
	assign forward_limit_input_o = flim_q;
	assign reverse_limit_input_o = rlim_q;
	assign reference_pulse_o     = u_sel.pulse_out;
	assign pulses_blocked_o      = u_sel.blocked;

endmodule

`default_nettype wire

// ### rtl/contact_sync.sv
// Contact synchroniser: inverts the active-low pins and filters the speed selects.
// Assumes pins may change at any time; a selection is taken once it has settled.
`timescale 1ns/1ps
`default_nettype none

module contact_sync
	import csms_pkg::*;
#(
	parameter int STAGES = SYNC_STAGES,
	parameter int SETTLE = SETTLE_CYCLES
) (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic rst_i,
	// Active-low contact pins
	input  wire logic multi_function_input_n_i,
	input  wire logic speed_select_a_n_i,
	input  wire logic speed_select_b_n_i,
	// Decoded contact levels
	sel_if.sync_mp    sel
);

	localparam int CNT_W = $clog2(SETTLE + 1);

	generate
		if (STAGES < 2 || SETTLE < 1) begin : g_bad
			$error("contact_sync: STAGES below 2 or SETTLE below 1");
		end
	endgenerate

	logic [2:0]       sync_q [STAGES];
	logic [2:0]       synced;
	logic [1:0]       cand_q;
	logic [1:0]       taken_q;
	logic             mfi_q;
	logic [CNT_W-1:0] cnt_q;

	// ------------------------------------------------------------
	// Synchroniser chain
	// ------------------------------------------------------------
	// Low pin means ON, so the chain carries the inverted level
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			for (int i = 0; i < STAGES; i++) begin
				sync_q[i] <= 3'h0;
			end
		end else begin
			sync_q[0] <= ~{multi_function_input_n_i, speed_select_a_n_i,
			               speed_select_b_n_i};
			for (int i = 1; i < STAGES; i++) begin
				sync_q[i] <= sync_q[i-1];
			end
		end
	end

	assign synced = sync_q[STAGES-1];

	// ------------------------------------------------------------
	// Settle filter on the speed selects
	// ------------------------------------------------------------
	// Both bits move as a pair, so a skewed edge never shows a third speed
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			cand_q  <= 2'h0;
			taken_q <= 2'h0;
			cnt_q   <= '0;
		end else if (synced[1:0] != cand_q) begin
			cand_q <= synced[1:0];
			cnt_q  <= '0;
		end else if (cand_q != taken_q) begin
			if (cnt_q == CNT_W'(SETTLE)) begin
				taken_q <= cand_q;
				cnt_q   <= '0;
			end else begin
				cnt_q <= cnt_q + CNT_W'(1);
			end
		end else begin
			cnt_q <= '0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			mfi_q <= 1'b0;
		end else begin
			mfi_q <= synced[2];
		end
	end

	assign sel.multi_function_on = mfi_q;
	assign sel.speed_a_on        = taken_q[1];
	assign sel.speed_b_on        = taken_q[0];

endmodule

`default_nettype wire

// ### rtl/csms_pkg.sv
// Constants, register map and enumerations for the contact speed and mode selector.
// Assumes a single 100 MHz clock and Avalon-MM register access with 32-bit words.
package csms_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ         = 100;
	localparam int SELECT_DELAY_US = 2000;
	localparam int SYNC_STAGES     = 2;
	// Longest delay rounds down; sync stages and output register come off the budget
	localparam int SETTLE_CYCLES   = SELECT_DELAY_US * CLK_MHZ - SYNC_STAGES - 3;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam int          ADDR_W      = 5;
	localparam logic [4:0]  OFS_CONTROL = 5'h00;
	localparam logic [4:0]  OFS_STATUS  = 5'h04;
	localparam logic [4:0]  OFS_SPEED1  = 5'h08;
	localparam logic [4:0]  OFS_SPEED2  = 5'h0C;
	localparam logic [4:0]  OFS_SPEED3  = 5'h10;

	// Control fields
	localparam int          CTL_METHOD_LSB = 0;
	localparam int          CTL_USAGE_LSB  = 4;
	localparam logic [3:0]  METHOD_RST     = 4'h0;
	localparam logic [1:0]  USAGE_RST      = 2'h0;

	// Preset speeds in rpm
	localparam int          SPEED_W    = 14;
	localparam logic [13:0] SPEED1_RST = 14'h0064;
	localparam logic [13:0] SPEED2_RST = 14'h00C8;
	localparam logic [13:0] SPEED3_RST = 14'h012C;

	// Status fields
	localparam int ST_DIR     = 0;
	localparam int ST_SRC_LSB = 1;
	localparam int ST_LOOP_LSB = 4;
	localparam int ST_BLOCKED = 6;
	localparam int ST_PMODE   = 7;
	localparam int ST_ZCLAMP  = 8;
	localparam int ST_INHIBIT = 9;
	localparam int ST_FLIM    = 10;
	localparam int ST_RLIM    = 11;
	localparam int ST_SOFT    = 12;
	localparam int ST_USAGE_LSB = 13;

	// ------------------------------------------------------------
	// Control method settings
	// ------------------------------------------------------------
	localparam logic [3:0] CM_SPEED       = 4'h0;
	localparam logic [3:0] CM_POSITION    = 4'h1;
	localparam logic [3:0] CM_TORQUE      = 4'h2;
	localparam logic [3:0] CM_CS_STOP     = 4'h3;
	localparam logic [3:0] CM_CS_ANALOG   = 4'h4;
	localparam logic [3:0] CM_CS_PULSE    = 4'h5;
	localparam logic [3:0] CM_CS_TORQUE   = 4'h6;
	localparam logic [3:0] CM_POS_SPD     = 4'h7;
	localparam logic [3:0] CM_POS_TRQ     = 4'h8;
	localparam logic [3:0] CM_TRQ_SPD     = 4'h9;
	localparam logic [3:0] CM_SPD_ZCLAMP  = 4'hA;
	localparam logic [3:0] CM_POS_INHIBIT = 4'hB;

	typedef enum logic [1:0] {
		LOOP_SPEED,
		LOOP_POSITION,
		LOOP_TORQUE
	} loop_e;

	typedef enum logic [2:0] {
		SRC_ZERO,
		SRC_ANALOG_SPEED,
		SRC_PULSE,
		SRC_ANALOG_TORQUE,
		SRC_PRESET1,
		SRC_PRESET2,
		SRC_PRESET3
	} src_e;

	typedef enum logic {
		GATE_OPEN,
		GATE_BLOCKED
	} gate_e;

	function automatic logic is_contact_speed(input logic [3:0] m);
		return (m == CM_CS_STOP) || (m == CM_CS_ANALOG) ||
		       (m == CM_CS_PULSE) || (m == CM_CS_TORQUE);
	endfunction

	function automatic logic is_preset(input src_e s);
		return (s == SRC_PRESET1) || (s == SRC_PRESET2) || (s == SRC_PRESET3);
	endfunction

endpackage

// ### rtl/pulse_gate.sv
// Reference pulse gate: holds pulses off after a running change from a preset speed into pulse mode.
// Assumes positioning complete comes from the position loop on the same clock.
`timescale 1ns/1ps
`default_nettype none

module pulse_gate
	import csms_pkg::*;
(
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic rst_i,
	// Gate signals
	sel_if.gate_mp    sel
);

	gate_e state_q;
	logic  block_now;
	logic  pulse_q;

	assign block_now = sel.enter_pulse & sel.motor_running;

	// ------------------------------------------------------------
	// Gate state
	// ------------------------------------------------------------
	// A fresh entry beats a completion seen in the same cycle
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_q <= GATE_OPEN;
		end else begin
			case (state_q)
				GATE_OPEN: begin
					if (block_now) begin
						state_q <= GATE_BLOCKED;
					end
				end
				GATE_BLOCKED: begin
					if (block_now) begin
						state_q <= GATE_BLOCKED;
					end else if (sel.positioning_complete || !sel.pulse_mode) begin
						state_q <= GATE_OPEN;
					end
				end
				default: state_q <= GATE_OPEN;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= sel.pulse_in & sel.pulse_mode & ~block_now &
			           (state_q == GATE_OPEN);
		end
	end

	assign sel.pulse_out = pulse_q;
	assign sel.blocked   = (state_q == GATE_BLOCKED);

endmodule

`default_nettype wire

// ### rtl/sel_if.sv
// Carrier between the selector top, its contact synchroniser and its pulse gate.
// Assumes all three parties run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface sel_if;
	logic multi_function_on;
	logic speed_a_on;
	logic speed_b_on;
	logic enter_pulse;
	logic motor_running;
	logic positioning_complete;
	logic pulse_in;
	logic pulse_mode;
	logic pulse_out;
	logic blocked;

	modport sync_mp (
		output multi_function_on,
		output speed_a_on,
		output speed_b_on
	);

	modport gate_mp (
		input  enter_pulse,
		input  motor_running,
		input  positioning_complete,
		input  pulse_in,
		input  pulse_mode,
		output pulse_out,
		output blocked
	);
endinterface

`default_nettype wire

// ### tb/contact_speed_mode_select_tb_top.sv
// Testbench top for the contact speed and mode selector.
// Assumes package, interface, design, checker and host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module contact_speed_mode_select_tb_top
	import csms_pkg::*;
;
	localparam int SETTLE = 8;
	localparam int LAT    = SETTLE + 8; // Scaled recognition bound
	localparam int PULSES = 3;
	logic clock_i = '0, rst_i = '1, avs_read_i = '0, avs_write_i = '0, ct, stray = '0;
	logic multi_function_input_n_i = '1, speed_select_a_n_i = '1, speed_select_b_n_i = '1;
	logic positioning_complete_i = '0, motor_running_i = '0, reference_pulse_i, host_pulse;
	logic reference_pulse_o, pulses_blocked_o, direction_reverse_o, soft_start_enable_o;
	logic proportional_only_o, zero_clamp_o, inhibit_o, forward_limit_input_o;
	logic reverse_limit_input_o, avs_waitrequest_o;
	logic [4:0] avs_address_i = '0;
	logic [31:0] avs_writedata_i = '0, avs_readdata_o, rdata;
	logic [1:0] loop_mode_o;
	logic [2:0] speed_source_o, es;
	logic [SPEED_W-1:0] preset_speed_o;
	logic [SPEED_W-1:0] spd [3] = '{14'h0064, 14'h00C8, 14'h012C};
	int seed = 32'h4D1B, fails = 0, n_compared = 0, n_out = 0, n0, cyc = 0;
	assign reference_pulse_i = host_pulse | stray;
	always #5 clock_i = ~clock_i;
	contact_speed_mode_select #(.SETTLE(SETTLE)) contact_speed_mode_select_i (
		.clock_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o,
		.multi_function_input_n_i, .speed_select_a_n_i, .speed_select_b_n_i,
		.positioning_complete_i, .motor_running_i, .reference_pulse_i, .reference_pulse_o,
		.pulses_blocked_o, .direction_reverse_o, .loop_mode_o, .speed_source_o,
		.preset_speed_o, .soft_start_enable_o, .proportional_only_o, .zero_clamp_o,
		.inhibit_o, .forward_limit_input_o, .reverse_limit_input_o);
	host_model #(.GAP(2 * LAT), .PULSES(PULSES)) host_model_i (
		.clock_i, .rst_i, .positioning_complete_i, .reference_pulse_o(host_pulse));
	always @(posedge clock_i) begin
		n_out <= n_out + int'(reference_pulse_o);
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fails++;
			end_sim;
		end
	end
	task automatic end_sim;
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %0t %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clock_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_read_i <= ~w;
		avs_write_i <= w;
		do @(posedge clock_i); while (avs_waitrequest_o !== 1'h0);
		rdata = avs_readdata_o;
		avs_read_i <= '0;
		avs_write_i <= '0;
	endtask
	task automatic pins(input logic f, input logic a, input logic b);
		@(posedge clock_i);
		multi_function_input_n_i <= ~f;
		speed_select_a_n_i <= ~a;
		speed_select_b_n_i <= ~b;
		repeat (LAT) @(posedge clock_i);
		@(negedge clock_i);
	endtask
	function automatic logic [1:0] exp_loop(input logic [3:0] m, input logic f,
	                                        input logic [1:0] ab);
		if (m >= 4'h3 && m <= 4'h6)
			return (ab != 2'h0) ? 2'h0 : (m == 4'h5) ? 2'h1 : (m == 4'h6) ? 2'h2 : 2'h0;
		case (m)
			4'h1, 4'hB: return 2'h1;
			4'h2: return 2'h2;
			4'h7: return f ? 2'h0 : 2'h1;
			4'h8: return f ? 2'h2 : 2'h1;
			4'h9: return f ? 2'h0 : 2'h2;
			default: return 2'h0;
		endcase
	endfunction
	function automatic logic [2:0] exp_src(input logic [3:0] m, input logic f,
	                                       input logic [1:0] ab);
		logic [1:0] l;
		l = exp_loop(m, f, ab);
		if (m >= 4'h3 && m <= 4'h6 && ab != 2'h0)
			return (ab == 2'h1) ? 3'h4 : (ab == 2'h3) ? 3'h5 : 3'h6;
		if (l != 2'h0) return {1'h0, l} + 3'h1;
		return ((m == 4'h3) || (m == 4'hA && f)) ? 3'h0 : 3'h1;
	endfunction
	initial begin
		repeat (2) @(posedge clock_i);
		rst_i <= '0;
		bus(1'h0, OFS_CONTROL, '0);
		chk(rdata, 32'h0, "control reset");
		bus(1'h0, 5'h14, '0);
		chk(rdata, 32'h0, "unmapped read");
		for (int i = 0; i < 3; i++) begin
			bus(1'h0, OFS_SPEED1 + 5'(4 * i), '0);
			chk(rdata, {18'h0, spd[i]}, "speed reset");
			spd[i] = 14'($random(seed));
			bus(1'h1, OFS_SPEED1 + 5'(4 * i), {18'h0, spd[i]});
		end
		$display("test registers done");
		for (int m = 0; m < 12; m++) begin
			bus(1'h1, OFS_CONTROL, 32'(m));
			ct = (m >= 3 && m <= 6);
			for (int k = 0; k < 8; k++) begin
				pins(k[2], k[1], k[0]);
				es = exp_src(4'(m), k[2], 2'(k));
				chk(speed_source_o, es, "source");
				chk(loop_mode_o, exp_loop(4'(m), k[2], 2'(k)), "loop");
				chk(direction_reverse_o, k[2] & ct, "direction");
				chk({forward_limit_input_o, reverse_limit_input_o}, 2'(k) & {2{~ct}}, "limits");
				chk({proportional_only_o, zero_clamp_o, inhibit_o},
				    {k[2] && m < 2, k[2] && m == 10, k[2] && m == 11}, "roles");
				chk(preset_speed_o, es[2] ? spd[es[1:0]] : '0, "preset");
				chk(soft_start_enable_o, ct && es != 3'h2 && es != 3'h3, "soft");
			end
		end
		$display("test modes done");
		bus(1'h1, OFS_CONTROL, 32'h5);
		motor_running_i <= '1;
		pins(1'h0, 1'h0, 1'h1);
		chk(speed_source_o, 3'h4, "preset one");
		pins(1'h0, 1'h0, 1'h0);
		chk(pulses_blocked_o, 1'h1, "blocked");
		n0 = n_out;
		@(posedge clock_i);
		stray <= '1;
		@(posedge clock_i);
		stray <= '0;
		positioning_complete_i <= '1;
		repeat (2 * LAT + 2 * PULSES + 4) @(posedge clock_i);
		@(negedge clock_i);
		chk(pulses_blocked_o, 1'h0, "reopened");
		chk(n_out - n0, PULSES, "pulses passed");
		$display("test pulse gate done");
		end_sim;
	end
endmodule
bind contact_speed_mode_select csms_assertions csms_assertions_i (
	.clock_i, .rst_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .positioning_complete_i,
	.motor_running_i, .reference_pulse_i, .reference_pulse_o, .pulses_blocked_o,
	.direction_reverse_o, .loop_mode_o, .speed_source_o, .preset_speed_o,
	.soft_start_enable_o, .proportional_only_o, .zero_clamp_o, .inhibit_o,
	.forward_limit_input_o, .reverse_limit_input_o);
`default_nettype wire

// ### tb/csms_assertions.sv
// Checker on the selector top ports: pulse gating, decode consistency, bus wait.
// Assumes it is bound to the top and shares its single clock and reset.
`timescale 1ns/1ps
`default_nettype none
module csms_assertions
	import csms_pkg::*;
(
	input wire logic               clock_i,
	input wire logic               rst_i,
	input wire logic               avs_read_i,
	input wire logic               avs_write_i,
	input wire logic               avs_waitrequest_o,
	input wire logic               positioning_complete_i,
	input wire logic               motor_running_i,
	input wire logic               reference_pulse_i,
	input wire logic               reference_pulse_o,
	input wire logic               pulses_blocked_o,
	input wire logic               direction_reverse_o,
	input wire logic [1:0]         loop_mode_o,
	input wire logic [2:0]         speed_source_o,
	input wire logic [SPEED_W-1:0] preset_speed_o,
	input wire logic               soft_start_enable_o,
	input wire logic               proportional_only_o,
	input wire logic               zero_clamp_o,
	input wire logic               inhibit_o,
	input wire logic               forward_limit_input_o,
	input wire logic               reverse_limit_input_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	a_pulse_gated: assert property (
		reference_pulse_o |-> $past(reference_pulse_i) && !$past(pulses_blocked_o))
		else $error("Pulse passed while gated");
	a_pulse_passes: assert property (
		(!pulses_blocked_o && speed_source_o == 3'h2 && reference_pulse_i)
		##1 (speed_source_o == 3'h2) |-> reference_pulse_o)
		else $error("Open gate dropped a pulse");
	a_block_holds: assert property (
		(pulses_blocked_o && !positioning_complete_i && speed_source_o == 3'h2)
		##1 (speed_source_o == 3'h2) |-> pulses_blocked_o)
		else $error("Gate opened without completion");
	a_block_release: assert property (
		pulses_blocked_o && positioning_complete_i |-> ##[1:2] !pulses_blocked_o)
		else $error("Gate stayed shut after completion");
	a_arm_on_entry: assert property (
		(speed_source_o >= 3'h4 && motor_running_i) ##1 (speed_source_o == 3'h2)
		|-> ##[0:1] pulses_blocked_o)
		else $error("Running entry not blocked");
	a_soft_no_pulse: assert property (
		speed_source_o == 3'h2 || loop_mode_o == 2'h2 |-> !soft_start_enable_o)
		else $error("Soft start on pulse or torque");
	a_soft_preset: assert property (
		speed_source_o >= 3'h4 |-> soft_start_enable_o)
		else $error("Soft start missing on preset");
	a_preset_zero: assert property (
		speed_source_o < 3'h4 |-> preset_speed_o == '0)
		else $error("Preset speed without preset");
	a_loop_source: assert property (
		((loop_mode_o == 2'h1) == (speed_source_o == 3'h2)) &&
		((loop_mode_o == 2'h2) == (speed_source_o == 3'h3)))
		else $error("Loop mode and source disagree");
	a_dir_alone: assert property (
		direction_reverse_o |-> !(proportional_only_o || zero_clamp_o || inhibit_o ||
		forward_limit_input_o || reverse_limit_input_o))
		else $error("Direction shares its input");
	a_one_wait: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("Bus wait longer than one cycle");
endmodule
`default_nettype wire

// ### tb/host_model.sv
// Host motion controller model: issues reference pulses once positioning completes.
// Assumes the selector clock; the long host wait is scaled down by GAP.
`timescale 1ns/1ps
`default_nettype none
module host_model #(
	parameter int GAP    = 32,
	parameter int PULSES = 3
) (
	input  wire logic clock_i,
	input  wire logic rst_i,
	input  wire logic positioning_complete_i,
	output logic      reference_pulse_o
);
	int cnt;
	always @(posedge clock_i) begin // Pulses wait for completion plus gap
		if (rst_i || !positioning_complete_i) begin
			cnt <= 0;
			reference_pulse_o <= '0;
		end else begin
			cnt <= cnt + 1;
			reference_pulse_o <= (cnt > GAP) && (cnt <= GAP + 2 * PULSES) && cnt[0];
		end
	end
endmodule
`default_nettype wire
